// ===== src/dcq_pkg.sv
package dcq_pkg;

	// ------------------------------------------------------------------
	// widths and counts
	// ------------------------------------------------------------------
	localparam int DATA_W   = 32;
	localparam int ADDR_W   = 8;
	localparam int NUM_DREG = 8;
	localparam int DIDX_W   = 3;
	localparam int NUM_IO   = 4;
	localparam int HEX_DIG  = 4;
	localparam int NV_IDX_W = 4;
	localparam logic [NV_IDX_W-1:0] NV_LAST = 4'h8;

	// ------------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_CMD   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_REPLY = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_DIR   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_SNAP  = 8'h10;
	localparam int                DREG_LSB  = 5;
	localparam logic [2:0]        DREG_SEL  = 3'h1;

	// ------------------------------------------------------------------
	// command word fields
	// ------------------------------------------------------------------
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_SRCA_LSB = 8;
	localparam int CMD_SRCB_LSB = 12;
	localparam int CMD_PT_LSB   = 16;
	localparam int CMD_DIR_LSB  = 24;
	localparam logic [2:0] PT_MIN = 3'h1;
	localparam logic [2:0] PT_MAX = 3'h4;

	// ------------------------------------------------------------------
	// control / status word fields
	// ------------------------------------------------------------------
	localparam int CC_T       = 0;
	localparam int CC_F       = 1;
	localparam int CC_N       = 2;
	localparam int CC_P       = 3;
	localparam int CC_Z       = 4;
	localparam int ST_SAVING  = 8;
	localparam int ST_REJECT  = 9;
	localparam int ST_RVALID  = 10;

	// ------------------------------------------------------------------
	// drive status word bit positions
	// ------------------------------------------------------------------
	localparam int SW_ENABLED = 0;
	localparam int SW_SAMPLE  = 1;
	localparam int SW_FAULT   = 2;
	localparam int SW_INPOS   = 3;
	localparam int SW_MOVING  = 4;
	localparam int SW_JOG     = 5;
	localparam int SW_STOP    = 6;
	localparam int SW_SAVING  = 8;
	localparam int SW_ALARM   = 9;
	localparam int SW_HOMING  = 10;
	localparam int SW_WAIT    = 11;
	localparam int SW_WIZARD  = 12;
	localparam int SW_ENCCHK  = 13;
	localparam int SW_PROGRUN = 14;
	localparam int SW_INIT    = 15;

	// ------------------------------------------------------------------
	// ascii codes and reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] ASCII_I    = 8'h49;
	localparam logic [7:0] ASCII_O    = 8'h4F;
	localparam logic [7:0] ASCII_ZERO = 8'h30;
	localparam logic [7:0] ASCII_ONE  = 8'h31;
	localparam logic [7:0] ASCII_HEXA = 8'h37;
	localparam logic [3:0] HEX_NINE   = 4'h9;
	localparam logic [NUM_IO-1:0] DIR_RST  = 4'hF;
	localparam logic [DATA_W-1:0] DREG_RST = 32'h0;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NONE, OP_OR, OP_SAVE, OP_STATUS, OP_DIR_SET, OP_DIR_QUERY
	} dcq_op_t;
	localparam int CMD_OP_W = 3;

	typedef enum logic [1:0] {SV_IDLE, SV_LOAD, SV_WAIT} dcq_sv_state_t;

endpackage

// ===== src/dcq_nv_saver.sv
`timescale 1ns/100ps
module dcq_nv_saver (
	// clock and reset
	input  wire logic                          mclk,
	input  wire logic                          resetn,
	input  wire logic                          clkEn,
	// request from command logic
	input  wire logic                          start,
	output logic                               busy,
	output logic [dcq_pkg::NV_IDX_W-1:0]       wordIdx,
	input  wire logic [dcq_pkg::DATA_W-1:0]    wordIn,
	// persistent storage port
	output logic                               nvReq,
	output logic [dcq_pkg::NV_IDX_W-1:0]       nvAddr,
	output logic [dcq_pkg::DATA_W-1:0]         nvData,
	input  wire logic                          nvAck
);
	import dcq_pkg::*;

	dcq_sv_state_t state;

	assign busy = (state != SV_IDLE);

	// ------------------------------------------------------------------
	// one word per storage handshake, in index order
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state   <= SV_IDLE;
			wordIdx <= '0;
			nvReq   <= 1'b0;
			nvAddr  <= '0;
			nvData  <= '0;
		end else if (clkEn) begin
			case (state)
				SV_IDLE: begin
					if (start) begin
						wordIdx <= '0;
						state   <= SV_LOAD;
					end
				end
				SV_LOAD: begin
					// word latched so storage sees stable data
					nvData <= wordIn;
					nvAddr <= wordIdx;
					nvReq  <= 1'b1;
					state  <= SV_WAIT;
				end
				SV_WAIT: begin
					if (nvAck) begin
						nvReq <= 1'b0;
						if (wordIdx == NV_LAST) begin
							state <= SV_IDLE;
						end else begin
							wordIdx <= wordIdx + 4'h1;
							state   <= SV_LOAD;
						end
					end
				end
				default: state <= SV_IDLE;
			endcase
		end
	end

endmodule

// ===== src/dcq_cmd_core.sv
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// drive command interpreter: register or, save, status, io direction
// ----------------------------------------------------------------------
// Contract
// - the or command writes the 32-bit or of two data registers to reg 0.
// - every register math operation updates the t, f, n, p, z flags.
// - the save command writes all non-volatile values to storage.
// - the status query is immediate, read only, and replies in hex digits.
// - the status word sets every bit whose condition currently holds.
// - bit 0001 shows motor enabled and bit 0002 shows sampling active.
// - bit 0004 shows a drive fault and bit 0200 an alarm present.
// - bits 0008, 0010, 0040 show in position, moving and stopping.
// - bit 0020 shows jogging and bit 0100 shows a save in progress.
// - bit 0400 shows homing and bit 0800 shows any timed or input wait.
// - bit 1000 shows the wizard running and bit 2000 encoder checking.
// - bit 4000 shows a program running and bit 8000 initialization.
// - a direction command with no parameter reports and changes nothing.
// - the direction report uses digit 1 for input and 0 for output.
module dcq_cmd_core (
	// clock and reset
	input  wire logic                          mclk,
	input  wire logic                          resetn,
	input  wire logic                          clkEn,
	// apb slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [dcq_pkg::ADDR_W-1:0]    paddr,
	input  wire logic [dcq_pkg::DATA_W-1:0]    pwdata,
	output logic [dcq_pkg::DATA_W-1:0]         prdata,
	output logic                               pready,
	output logic                               pslverr,
	// drive conditions
	input  wire logic                          motorEnabled,
	input  wire logic                          sampling,
	input  wire logic                          driveFault,
	input  wire logic                          inPosition,
	input  wire logic                          moving,
	input  wire logic                          stopping,
	input  wire logic                          jogging,
	input  wire logic                          alarmPresent,
	input  wire logic                          homing,
	input  wire logic                          waitInput,
	input  wire logic                          waitTime,
	input  wire logic                          wizardRunning,
	input  wire logic                          encoderCheck,
	input  wire logic                          programRunning,
	input  wire logic                          initializing,
	// io direction
	output logic [dcq_pkg::NUM_IO-1:0]         ioIsInput,
	// persistent storage
	output logic                               nvReq,
	output logic [dcq_pkg::NV_IDX_W-1:0]       nvAddr,
	output logic [dcq_pkg::DATA_W-1:0]         nvData,
	input  wire logic                          nvAck
);
	import dcq_pkg::*;

	// ------------------------------------------------------------------
	// storage and decode signals
	// ------------------------------------------------------------------
	logic [DATA_W-1:0]   dataReg [0:NUM_DREG-1];
	logic [4:0]          condCode;
	logic [NUM_IO-1:0]   dirReg;
	logic [DATA_W-1:0]   reply;
	logic                replyValid;
	logic [15:0]         snapWord;
	logic                rejected;
	logic [15:0]         statusWord;
	logic [DATA_W-1:0]   hexReply;
	logic [DATA_W-1:0]   dirReply;
	logic                apbAccess;
	logic                apbWr;
	logic                cmdFire;
	dcq_op_t             cmdOp;
	logic [DIDX_W-1:0]   srcA;
	logic [DIDX_W-1:0]   srcB;
	logic [2:0]          ptNum;
	logic [1:0]          ptIdx;
	logic [7:0]          dirLetter;
	logic                cmdOk;
	logic                saveBusy;
	logic                orFire;
	logic                saveFire;
	logic                statusFire;
	logic                dirSetFire;
	logic                dirQueryFire;
	logic                rejectSet;
	logic [DATA_W-1:0]   orResult;
	logic                dregHit;
	logic [DIDX_W-1:0]   dregIdx;
	logic                addrHit;
	logic [DATA_W-1:0]   rdData;
	logic [DATA_W-1:0]   ctrlWord;
	logic [NV_IDX_W-1:0] saveIdx;
	logic [DATA_W-1:0]   saveWord;

	// ------------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------------
	assign pready    = clkEn;
	assign apbAccess = psel & penable & clkEn;
	assign apbWr     = apbAccess & pwrite;
	assign cmdFire   = apbWr & (paddr == OFF_CMD);
	assign cmdOp     = dcq_op_t'(pwdata[CMD_OP_LSB +: CMD_OP_W]);
	assign srcA      = pwdata[CMD_SRCA_LSB +: DIDX_W];
	assign srcB      = pwdata[CMD_SRCB_LSB +: DIDX_W];
	assign ptNum     = pwdata[CMD_PT_LSB +: 3];
	assign ptIdx     = 2'(ptNum - PT_MIN);
	assign dirLetter = pwdata[CMD_DIR_LSB +: 8];
	assign orResult  = dataReg[srcA] | dataReg[srcB];

	always_comb begin
		case (cmdOp)
			OP_OR:        cmdOk = 1'b1;
			OP_SAVE:      cmdOk = 1'b1;
			OP_DIR_QUERY: cmdOk = 1'b1;
			// malformed point or letter is refused, not guessed
			OP_DIR_SET:   cmdOk = (ptNum >= PT_MIN) && (ptNum <= PT_MAX) &&
			                ((dirLetter == ASCII_I) ||
			                 (dirLetter == ASCII_O));
			default:      cmdOk = 1'b0;
		endcase
	end

	// status is immediate; buffered ones wait out a save by refusal
	assign statusFire   = cmdFire & (cmdOp == OP_STATUS);
	assign orFire       = cmdFire & (cmdOp == OP_OR) & ~saveBusy;
	assign saveFire     = cmdFire & (cmdOp == OP_SAVE) & ~saveBusy;
	assign dirSetFire   = cmdFire & (cmdOp == OP_DIR_SET) & cmdOk & ~saveBusy;
	assign dirQueryFire = cmdFire & (cmdOp == OP_DIR_QUERY) & ~saveBusy;
	assign rejectSet    = cmdFire & (cmdOp != OP_STATUS) & (saveBusy | ~cmdOk);

	// ------------------------------------------------------------------
	// data registers, entry 0 is the accumulator
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_DREG; g++) begin : gDreg
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					dataReg[g] <= DREG_RST;
				end else if (clkEn) begin
					if (apbWr && dregHit && dregIdx == DIDX_W'(g)) begin
						dataReg[g] <= pwdata;
					end else if (g == 0 && orFire) begin
						dataReg[g] <= orResult;
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// condition codes
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			condCode <= '0;
		end else if (clkEn && orFire) begin
			condCode[CC_T] <= (orResult != '0);
			condCode[CC_F] <= (orResult == '0);
			condCode[CC_N] <= orResult[DATA_W-1];
			condCode[CC_P] <= ~orResult[DATA_W-1] & (orResult != '0);
			condCode[CC_Z] <= (orResult == '0);
		end
	end

	// ------------------------------------------------------------------
	// io direction
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			dirReg <= DIR_RST;
		end else if (clkEn && dirSetFire) begin
			dirReg[ptIdx] <= (dirLetter == ASCII_I);
		end
	end
	assign ioIsInput = dirReg;

	// ------------------------------------------------------------------
	// status word and ascii replies
	// ------------------------------------------------------------------
	always_comb begin
		statusWord             = '0;
		statusWord[SW_ENABLED] = motorEnabled;
		statusWord[SW_SAMPLE]  = sampling;
		statusWord[SW_FAULT]   = driveFault;
		statusWord[SW_ALARM]   = alarmPresent;
		statusWord[SW_INPOS]   = inPosition;
		statusWord[SW_MOVING]  = moving;
		statusWord[SW_STOP]    = stopping;
		statusWord[SW_JOG]     = jogging;
		statusWord[SW_SAVING]  = saveBusy;
		statusWord[SW_HOMING]  = homing;
		statusWord[SW_WAIT]    = waitInput | waitTime;
		statusWord[SW_WIZARD]  = wizardRunning;
		statusWord[SW_ENCCHK]  = encoderCheck;
		statusWord[SW_PROGRUN] = programRunning;
		statusWord[SW_INIT]    = initializing;
	end

	// most significant digit lands in the top byte, sent first
	generate
		for (g = 0; g < HEX_DIG; g++) begin : gChar
			logic [3:0] nib;
			assign nib = statusWord[4*g +: 4];
			assign hexReply[8*g +: 8] = (nib > HEX_NINE) ?
				8'(nib + ASCII_HEXA) : 8'(nib + ASCII_ZERO);
			assign dirReply[8*g +: 8] = dirReg[g] ?
				ASCII_ONE : ASCII_ZERO;
		end
	endgenerate

	// one edge captures word and text together
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			snapWord <= '0;
			reply    <= '0;
		end else if (clkEn) begin
			if (statusFire) begin
				snapWord <= statusWord;
				reply    <= hexReply;
			end else if (dirQueryFire) begin
				reply <= dirReply;
			end
		end
	end

	// set wins over the clear by read
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			replyValid <= 1'b0;
		end else if (clkEn) begin
			if (statusFire || dirQueryFire) begin
				replyValid <= 1'b1;
			end else if (apbAccess && !pwrite && paddr == OFF_REPLY) begin
				replyValid <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rejected <= 1'b0;
		end else if (clkEn) begin
			if (rejectSet) begin
				rejected <= 1'b1;
			end else if (apbWr && paddr == OFF_CTRL && pwdata[ST_REJECT]) begin
				rejected <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// save sequencer
	// ------------------------------------------------------------------
	assign saveWord = (saveIdx < NV_IDX_W'(NUM_DREG)) ?
		dataReg[saveIdx[DIDX_W-1:0]] : DATA_W'(dirReg);

	dcq_nv_saver uSaver (
		.mclk    (mclk),
		.resetn  (resetn),
		.clkEn   (clkEn),
		.start   (saveFire),
		.busy    (saveBusy),
		.wordIdx (saveIdx),
		.wordIn  (saveWord),
		.nvReq   (nvReq),
		.nvAddr  (nvAddr),
		.nvData  (nvData),
		.nvAck   (nvAck)
	);

	// ------------------------------------------------------------------
	// apb read path
	// ------------------------------------------------------------------
	assign dregIdx = paddr[DREG_LSB-1:2];

	always_comb begin
		ctrlWord            = '0;
		ctrlWord[4:0]       = condCode;
		ctrlWord[ST_SAVING] = saveBusy;
		ctrlWord[ST_REJECT] = rejected;
		ctrlWord[ST_RVALID] = replyValid;
	end

	always_comb begin
		rdData  = '0;
		addrHit = 1'b1;
		dregHit = 1'b0;
		if (paddr == OFF_CMD) begin
			rdData = '0;
		end else if (paddr == OFF_CTRL) begin
			rdData = ctrlWord;
		end else if (paddr == OFF_REPLY) begin
			rdData = reply;
		end else if (paddr == OFF_DIR) begin
			rdData = DATA_W'(dirReg);
		end else if (paddr == OFF_SNAP) begin
			rdData = DATA_W'(snapWord);
		end else if (paddr[ADDR_W-1:DREG_LSB] == DREG_SEL &&
		             paddr[1:0] == 2'h0) begin
			dregHit = 1'b1;
			rdData  = dataReg[dregIdx];
		end else begin
			addrHit = 1'b0;
		end
	end

	assign pslverr = psel & penable & ~addrHit;

	// loaded every selected cycle so it is ready before pready completes
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			prdata <= '0;
		end else if (clkEn && psel) begin
			prdata <= rdData;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	property p_or_result;
		orFire |=> dataReg[0] == $past(orResult);
	endproperty
	a_or_result: assert property (p_or_result)
		else $error("or result not in accumulator");

	property p_cc_zero;
		orFire |=> condCode[CC_Z] == ($past(orResult) == '0) &&
			condCode[CC_N] == $past(orResult[DATA_W-1]);
	endproperty
	a_cc_zero: assert property (p_cc_zero)
		else $error("condition codes wrong after or");

	property p_save_start;
		saveFire |=> saveBusy ##1 nvReq;
	endproperty
	a_save_start: assert property (p_save_start)
		else $error("save did not start storage writes");

	property p_status_imm;
		statusFire |=> replyValid && snapWord == $past(statusWord);
	endproperty
	a_status_imm: assert property (p_status_imm)
		else $error("status query not served at once");

	property p_snap_hold;
		!statusFire |=> $stable(snapWord);
	endproperty
	a_snap_hold: assert property (p_snap_hold)
		else $error("status snapshot moved without a query");

	property p_fault_bit;
		statusFire && driveFault && alarmPresent |=>
			snapWord[SW_FAULT] && snapWord[SW_ALARM];
	endproperty
	a_fault_bit: assert property (p_fault_bit)
		else $error("fault or alarm bit missing");

	property p_save_bit;
		statusFire && saveBusy |=> snapWord[SW_SAVING];
	endproperty
	a_save_bit: assert property (p_save_bit)
		else $error("saving bit missing during save");

	property p_dir_query;
		dirQueryFire |=> $stable(dirReg) &&
			reply[7:0] == (dirReg[0] ? ASCII_ONE : ASCII_ZERO);
	endproperty
	a_dir_query: assert property (p_dir_query)
		else $error("direction query changed or misreported");

	property p_dir_set;
		dirSetFire && dirLetter == ASCII_O |=> !dirReg[$past(ptIdx)];
	endproperty
	a_dir_set: assert property (p_dir_set)
		else $error("output direction not applied");

	c_or:     cover property (orFire);
	c_save:   cover property (saveFire ##[1:60] !saveBusy);
	c_status: cover property (statusFire && driveFault);
	c_query:  cover property (dirSetFire ##[1:40] dirQueryFire);

endmodule

// ===== tb/dcq_nv_store.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// persistent storage model: takes one word per request
// ----------------------------------------------------------------------
module dcq_nv_store (
	// clock and reset
	input  wire logic                       mclk,
	input  wire logic                       resetn,
	// storage port
	input  wire logic                       nvReq,
	input  wire logic [dcq_pkg::NV_IDX_W-1:0] nvAddr,
	input  wire logic [dcq_pkg::DATA_W-1:0]   nvData,
	output logic                            nvAck,
	// answer delay in cycles, zero answers promptly
	input  wire logic [3:0]                 delay
);
	import dcq_pkg::*;

	logic [DATA_W-1:0] mem [0:8];
	logic [3:0]        waitCnt;

	// a slow answer keeps nvReq up, so a drifting address or data shows
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			nvAck <= 1'h0;
			waitCnt <= 4'h0;
		end else if (nvReq && !nvAck) begin
			if (waitCnt >= delay) begin
				nvAck <= 1'h1;
				mem[nvAddr] <= nvData;
				waitCnt <= 4'h0;
			end else begin
				waitCnt <= waitCnt + 4'h1;
			end
		end else begin
			nvAck <= 1'h0;
		end
	end
endmodule

// ===== tb/test_drive_cmd_or_status_io_dir.sv
`timescale 1ns/100ps
module test_drive_cmd_or_status_io_dir;
	import dcq_pkg::*;

	// ------------------------------------------------------------------
	// clock, bus and conditions
	// ------------------------------------------------------------------
	logic mclk = 1'h0;
	logic resetn = 1'h0;
	logic clkEn = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [DATA_W-1:0] pwdata = 32'h0;
	logic [DATA_W-1:0] prdata, rdat, nvData;
	logic pready, pslverr, rerr, nvReq, nvAck;
	logic [14:0] cond = 15'h0000;
	logic [NUM_IO-1:0] ioIsInput;
	logic [NV_IDX_W-1:0] nvAddr;
	int n_mismatch = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [15:0] wt [15] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
		16'h0010, 16'h0020, 16'h0040, 16'h0200, 16'h0400, 16'h0800,
		16'h0800, 16'h1000, 16'h2000, 16'h4000, 16'h8000};

	always #12.5 mclk = ~mclk;

	dcq_cmd_core u_dut (
		.mclk(mclk), .resetn(resetn), .clkEn(clkEn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.motorEnabled(cond[0]), .sampling(cond[1]), .driveFault(cond[2]),
		.inPosition(cond[3]), .moving(cond[4]), .jogging(cond[5]),
		.stopping(cond[6]), .alarmPresent(cond[7]), .homing(cond[8]),
		.waitInput(cond[9]), .waitTime(cond[10]), .wizardRunning(cond[11]),
		.encoderCheck(cond[12]), .programRunning(cond[13]),
		.initializing(cond[14]), .ioIsInput(ioIsInput), .nvReq(nvReq),
		.nvAddr(nvAddr), .nvData(nvData), .nvAck(nvAck)
	);

	dcq_nv_store u_nv (
		.mclk(mclk), .resetn(resetn), .nvReq(nvReq), .nvAddr(nvAddr),
		.nvData(nvData), .nvAck(nvAck), .delay(4'h3)
	);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task conclude;
		$display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// request held until pready is seen high at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do @(posedge mclk); while (pready !== 1'h1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	function logic [31:0] cw(input logic [2:0] op, a, b, pt,
		input logic [7:0] ch);
		return {ch, 5'h00, pt, 1'h0, b, 1'h0, a, 5'h00, op};
	endfunction

	function logic [7:0] hx(input logic [3:0] n);
		return (n > 4'h9) ? 8'h37 + 8'(n) : 8'h30 + 8'(n);
	endfunction

	function logic [7:0] da(input int i);
		return {3'h1, i[2:0], 2'h0};
	endfunction

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task t_bad;
		apb(1'h0, 8'h14, 32'h0);
		chk({rerr, rdat[30:0]}, 32'h80000000);
	endtask

	task t_or;
		logic [31:0] av [3] = '{32'h800000F0, 32'h0, 32'h00000001};
		logic [31:0] bv [3] = '{32'h00000F01, 32'h0, 32'h00000100};
		logic [4:0] cc [3] = '{5'h05, 5'h12, 5'h09};
		for (int i = 0; i < 3; i++) begin
			apb(1'h1, da(1), av[i]);
			apb(1'h1, da(7), bv[i]);
			apb(1'h1, OFF_CMD, cw(3'h1, 3'h1, 3'h7, 3'h0, 8'h00));
			apb(1'h0, da(0), 32'h0);
			chk(rdat, av[i] | bv[i]);
			apb(1'h0, OFF_CTRL, 32'h0);
			chk(rdat[4:0], cc[i]);
		end
	endtask

	task st(input logic [14:0] c);
		logic [15:0] e;
		e = 16'h0;
		for (int i = 0; i < 15; i++)
			if (c[i])
				e = e | wt[i];
		cond <= c;
		repeat (2) @(posedge mclk);
		apb(1'h1, OFF_CMD, cw(3'h3, 3'h0, 3'h0, 3'h0, 8'h00));
		apb(1'h0, OFF_SNAP, 32'h0);
		chk(rdat[15:0], e);
		apb(1'h0, OFF_REPLY, 32'h0);
		chk(rdat, {hx(e[15:12]), hx(e[11:8]), hx(e[7:4]), hx(e[3:0])});
	endtask

	task t_status;
		for (int i = 0; i < 15; i++)
			st(15'h0001 << i);
		st(15'h0089);
		st(15'h7FFF);
		st(15'h0000);
	endtask

	task t_dir;
		logic [31:0] bad [3];
		bad = '{cw(3'h4, 3'h0, 3'h0, 3'h5, ASCII_O),
			cw(3'h4, 3'h0, 3'h0, 3'h0, ASCII_I),
			cw(3'h4, 3'h0, 3'h0, 3'h1, 8'h30)};
		apb(1'h1, OFF_CMD, cw(3'h4, 3'h0, 3'h0, 3'h2, ASCII_O));
		apb(1'h1, OFF_CMD, cw(3'h4, 3'h0, 3'h0, 3'h4, ASCII_O));
		apb(1'h1, OFF_CMD, cw(3'h4, 3'h0, 3'h0, 3'h4, ASCII_I));
		apb(1'h1, OFF_CMD, cw(3'h4, 3'h0, 3'h0, 3'h3, ASCII_O));
		for (int i = 0; i < 3; i++) begin
			apb(1'h1, OFF_CMD, bad[i]);
			apb(1'h0, OFF_CTRL, 32'h0);
			chk(rdat[9], 1'h1);
			apb(1'h1, OFF_CTRL, 32'h00000200);
		end
		apb(1'h1, OFF_CMD, cw(3'h5, 3'h0, 3'h0, 3'h0, 8'h00));
		apb(1'h0, OFF_CTRL, 32'h0);
		chk(rdat[10], 1'h1);
		apb(1'h0, OFF_REPLY, 32'h0);
		chk(rdat, 32'h31303031);
		apb(1'h0, OFF_CTRL, 32'h0);
		chk(rdat[10], 1'h0);
		apb(1'h0, OFF_DIR, 32'h0);
		chk(rdat, 32'h00000009);
		chk(ioIsInput, 4'h9);
	endtask

	task t_save;
		int n;
		for (int i = 0; i < 8; i++)
			apb(1'h1, da(i), 32'h5A000000 + 32'(i));
		apb(1'h1, OFF_CMD, cw(3'h2, 3'h0, 3'h0, 3'h0, 8'h00));
		// a set while saving must be turned away, status still answered
		apb(1'h1, OFF_CMD, cw(3'h4, 3'h0, 3'h0, 3'h1, ASCII_O));
		apb(1'h1, OFF_CMD, cw(3'h3, 3'h0, 3'h0, 3'h0, 8'h00));
		apb(1'h0, OFF_SNAP, 32'h0);
		chk(rdat[15:0], 16'h0100);
		n = 0;
		do begin
			apb(1'h0, OFF_CTRL, 32'h0);
			n++;
		end while (rdat[8] !== 1'h0 && n < 200);
		chk(rdat[9:8], 2'h2);
		for (int i = 0; i < 8; i++)
			chk(u_nv.mem[i], 32'h5A000000 + 32'(i));
		chk(u_nv.mem[8], 32'h00000009);
	endtask

	// ------------------------------------------------------------------
	// run
	// ------------------------------------------------------------------
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			conclude();
		end
	end

	initial begin
		repeat (12) @(posedge mclk);
		resetn <= 1'h1;
		t_bad();
		t_or();
		t_status();
		t_dir();
		t_save();
		conclude();
	end
endmodule
